// file: qsf_ctrl.sv
// Purpose: APB control and status of a quad serial flash master
// Assumes: Flash link clock unrelated to clk_i; software avoids reserved codes
// Notes:   One byte per link request; transfer runs over the programmed count
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
// How it works
// - With the status-check bit set, a status read runs after the count and waits until not busy.
// - With the release bit set, chip select drops after the count, else it stays asserted after the count, or after the status read when one runs.
// - Device select code 00 picks device 0 and 01 picks device 1, others are not used.
// - Lane width code 00 is single, 01 dual, 10 quad, 11 unused.
// - Transmit mode starts bytes on a transmit write or buffered transmit data.
// - Receive mode starts bytes on a receive read or free receive space.
// - Mode 00 keeps the block idle with no commands started.
// - The 16-bit count sets how many bytes move, direction from the mode.
// - Bits 31 to 25 and bit 23 read as zero.
// - Status bits 23 to 16 give free transmit words.
// - Status bits 7 to 0 give held receive words.
module qsf_ctrl (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        link_clk_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Flash pins
   output logic [1:0]       cs_n_o,
   output logic [3:0]       io_o,
   output logic [3:0]       io_oe_o,
   input  wire logic [3:0]  io_i
);
   typedef enum logic [2:0] {S_IDLE, S_REQ, S_WAIT, S_POLL, S_PWAIT} ctrl_state_e;
   localparam int FD = qsf_pkg::FIFO_DEPTH;
   ctrl_state_e state_reg, state_next;
   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic [7:0]  txq_reg [FD], txq_next [FD];
   logic [7:0]  rxq_reg [FD], rxq_next [FD];
   logic [7:0]  txn_reg, txn_next, rxn_reg, rxn_next;
   logic [15:0] left_reg, left_next;
   logic        req_reg, req_next, hold_reg, hold_next, dir_reg, dir_next;
   logic [7:0]  byte_reg, byte_next;
   logic [2:0]  gap_reg, gap_next;
   logic        frame_ok;
   logic [2:0]  ack_sync_reg;
   logic        link_ack;
   logic [7:0]  link_rx;
   logic        acc, wr_acc, rd_acc, ack_seen;
   logic [1:0]  mode;
   assign mode = ctrl_reg[qsf_pkg::MODE_LSB +: 2];
   assign acc = psel_i & penable_i & ~pready_reg;
   assign wr_acc = acc & pwrite_i;
   assign rd_acc = acc & ~pwrite_i;
   assign ack_seen = ack_sync_reg[2] != ack_sync_reg[1];
   // A new frame waits until select has stayed released long enough for the link to see it
   assign frame_ok = hold_reg | (gap_reg == qsf_pkg::CS_GAP_CYCLES);
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_sync_reg <= 3'b000;
      end else begin
         ack_sync_reg <= {ack_sync_reg[1:0], link_ack};
      end
   end
   always_comb begin
      ctrl_next = ctrl_reg;
      prdata_next = prdata_reg;
      pready_next = acc;
      pslverr_next = 1'b0;
      txq_next = txq_reg;
      rxq_next = rxq_reg;
      txn_next = txn_reg;
      rxn_next = rxn_reg;
      state_next = state_reg;
      left_next = left_reg;
      req_next = req_reg;
      hold_next = hold_reg;
      dir_next = dir_reg;
      byte_next = byte_reg;
      if (hold_reg) begin
         gap_next = 3'h0;
      end else if (gap_reg == qsf_pkg::CS_GAP_CYCLES) begin
         gap_next = gap_reg;
      end else begin
         gap_next = gap_reg + 3'h1;
      end
      if (wr_acc) begin
         case (paddr_i)
            qsf_pkg::CTRL_OFFSET: begin
               ctrl_next = pwdata_i & qsf_pkg::CTRL_WRITE_MASK;
               left_next = pwdata_i[qsf_pkg::COUNT_LSB +: 16];
            end
            qsf_pkg::TXDATA_OFFSET: begin
               if (txn_reg < 8'(FD)) begin
                  txq_next[txn_reg[1:0]] = pwdata_i[7:0];
                  txn_next = txn_reg + 8'd1;
               end else begin
                  pslverr_next = 1'b1;
               end
            end
            qsf_pkg::STAT_OFFSET: pslverr_next = 1'b0;
            default: pslverr_next = 1'b1;
         endcase
      end
      if (rd_acc) begin
         case (paddr_i)
            qsf_pkg::CTRL_OFFSET: prdata_next = ctrl_reg;
            qsf_pkg::STAT_OFFSET: begin
               prdata_next = 32'h0000_0000;
               prdata_next[qsf_pkg::TXFREE_LSB +: 8] = 8'(FD) - txn_reg;
               prdata_next[qsf_pkg::RXCNT_LSB +: 8] = rxn_reg;
            end
            qsf_pkg::RXDATA_OFFSET: begin
               prdata_next = {24'h00_0000, rxq_reg[0]};
               if (rxn_reg != 8'd0) begin
                  for (int i = 0; i < FD - 1; i++) begin
                     rxq_next[i] = rxq_reg[i + 1];
                  end
                  rxn_next = rxn_reg - 8'd1;
               end
            end
            default: begin
               prdata_next = 32'h0000_0000;
               pslverr_next = 1'b1;
            end
         endcase
      end
      case (state_reg)
         S_IDLE: begin
            // Select stays asserted between the bytes of one count
            if (left_reg == 16'd0 && ctrl_reg[qsf_pkg::RELEASE_BIT]) begin
               hold_next = 1'b0;
            end
            if (left_reg != 16'd0 && mode == qsf_pkg::MODE_TX && txn_next != 8'd0) begin
               byte_next = txq_next[0];
               for (int i = 0; i < FD - 1; i++) begin
                  txq_next[i] = txq_next[i + 1];
               end
               txn_next = txn_next - 8'd1;
               dir_next = 1'b0;
               state_next = S_REQ;
            end else if (left_reg != 16'd0 && mode == qsf_pkg::MODE_RX
                         && rxn_next < 8'(FD)) begin
               byte_next = 8'h00;
               dir_next = 1'b1;
               state_next = S_REQ;
            end
         end
         S_REQ: begin
            if (frame_ok) begin
               hold_next = 1'b1;
               req_next = ~req_reg;
               state_next = S_WAIT;
            end
         end
         S_WAIT: begin
            if (ack_seen) begin
               if (dir_reg) begin
                  rxq_next[rxn_next[1:0]] = link_rx;
                  rxn_next = rxn_next + 8'd1;
               end
               left_next = left_reg - 16'd1;
               if (left_reg == 16'd1) begin
                  hold_next = ~ctrl_reg[qsf_pkg::RELEASE_BIT];
                  if (ctrl_reg[qsf_pkg::CHECK_BIT]) begin
                     hold_next = 1'b0;
                     state_next = S_POLL;
                  end else begin
                     state_next = S_IDLE;
                  end
               end else begin
                  state_next = S_IDLE;
               end
            end
         end
         S_POLL: begin
            byte_next = qsf_pkg::STATUS_READ_CMD;
            dir_next = 1'b0;
            if (frame_ok) begin
               hold_next = 1'b1;
               req_next = ~req_reg;
               state_next = S_PWAIT;
            end
         end
         S_PWAIT: begin
            if (ack_seen) begin
               if (dir_reg) begin
                  hold_next = ~ctrl_reg[qsf_pkg::RELEASE_BIT];
                  state_next = ((link_rx & qsf_pkg::BUSY_STATUS_MASK) != 8'h00) ? S_POLL : S_IDLE;
                  hold_next = (state_next == S_POLL) ? 1'b0 : hold_next;
               end else begin
                  dir_next = 1'b1;
                  req_next = ~req_reg;
               end
            end
         end
         default: state_next = S_IDLE;
      endcase
   end
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_reg <= qsf_pkg::CTRL_RESET;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         for (int i = 0; i < FD; i++) begin
            txq_reg[i] <= 8'h00;
            rxq_reg[i] <= 8'h00;
         end
         txn_reg <= 8'h00;
         rxn_reg <= 8'h00;
         state_reg <= S_IDLE;
         left_reg <= 16'h0000;
         req_reg <= 1'b0;
         hold_reg <= 1'b0;
         dir_reg <= 1'b0;
         byte_reg <= 8'h00;
         gap_reg <= 3'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         txq_reg <= txq_next;
         rxq_reg <= rxq_next;
         txn_reg <= txn_next;
         rxn_reg <= rxn_next;
         state_reg <= state_next;
         left_reg <= left_next;
         req_reg <= req_next;
         hold_reg <= hold_next;
         dir_reg <= dir_next;
         byte_reg <= byte_next;
         gap_reg <= gap_next;
      end
   end
   // Byte, direction and select hold are held stable while a request is in flight; lane and device follow ctrl_reg
   qsf_link u_link (
      .link_clk_i (link_clk_i),
      .resetn_i   (resetn_i),
      .req_tgl_i  (req_reg),
      .tx_byte_i  (byte_reg),
      .lane_i     (ctrl_reg[qsf_pkg::LANE_LSB +: 2]),
      .dir_rx_i   (dir_reg),
      .cs_hold_i  (hold_reg),
      .dev_i      (ctrl_reg[qsf_pkg::TARGET_DEVICE_SELECT_LSB]),
      .ack_tgl_o  (link_ack),
      .rx_byte_o  (link_rx),
      .cs_n_o     (cs_n_o),
      .io_o       (io_o),
      .io_oe_o    (io_oe_o),
      .io_i       (io_i)
   );
   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;

   reserved_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ctrl_reg[31:25] == 7'h00 && ctrl_reg[23] == 1'b0) else $error("reserved bits set");
   idle_mode_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_reg == S_IDLE && mode == qsf_pkg::MODE_IDLE) |=> state_reg != S_REQ)
      else $error("command started in idle mode");
   tx_free_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      txn_reg <= 8'(FD)) else $error("tx level out of range");
   rx_cnt_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rxn_reg <= 8'(FD)) else $error("rx level out of range");
   count_done_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_reg == S_WAIT && ack_seen) |=> left_reg == $past(left_reg) - 16'd1
      || $past(wr_acc)) else $error("count not decremented");
   release_cs_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_reg == S_WAIT && ack_seen && left_reg == 16'd1
       && ctrl_reg[qsf_pkg::RELEASE_BIT]) |=> !hold_reg) else $error("cs held");
   check_poll_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_reg == S_WAIT && ack_seen && left_reg == 16'd1
       && ctrl_reg[qsf_pkg::CHECK_BIT]) |=> state_reg == S_POLL) else $error("no poll");
   apb_ready_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (psel_i && penable_i && !pready_reg) |=> pready_reg) else $error("late ready");

   // Steps of a byte handshake and of a status poll
   sequence last_byte_s;
      state_reg == S_WAIT && ack_seen && left_reg == 16'd1;
   endsequence
   sequence poll_answer_s;
      state_reg == S_PWAIT && ack_seen && dir_reg;
   endsequence
   hold_kept_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_reg == S_WAIT && ack_seen && left_reg > 16'd1) |=> hold_reg)
      else $error("chip select dropped inside count");
   held_after_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      last_byte_s ##0 (!ctrl_reg[qsf_pkg::RELEASE_BIT] && !ctrl_reg[qsf_pkg::CHECK_BIT])
      |=> hold_reg) else $error("chip select released");
   poll_again_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      poll_answer_s ##0 ((link_rx & qsf_pkg::BUSY_STATUS_MASK) != 8'h00)
      |=> state_reg == S_POLL && !hold_reg) else $error("busy flash not polled");
   poll_done_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      poll_answer_s ##0 ((link_rx & qsf_pkg::BUSY_STATUS_MASK) == 8'h00)
      |=> state_reg == S_IDLE) else $error("poll did not finish");
   tx_start_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_reg == S_IDLE && mode == qsf_pkg::MODE_TX && left_reg != 16'd0
       && txn_reg != 8'h00) |=> state_reg == S_REQ && !dir_reg)
      else $error("transmit byte not started");
   rx_start_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_reg == S_IDLE && mode == qsf_pkg::MODE_RX && left_reg != 16'd0
       && rxn_reg < 8'(FD)) |=> state_reg == S_REQ && dir_reg)
      else $error("receive byte not started");
   gap_wait_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_reg == S_REQ && !frame_ok) |=> state_reg == S_REQ && req_reg == $past(req_reg))
      else $error("frame started without select gap");
endmodule // qsf_ctrl

// file: qsf_pkg.sv
// Purpose: Shared constants for the quad serial flash control block
// Assumes: APB register access, 32-bit data
// Notes:   Offsets are byte addresses on APB
package qsf_pkg;
   localparam logic [11:0] CTRL_OFFSET       = 12'h000;
   localparam logic [11:0] STAT_OFFSET       = 12'h004;
   localparam logic [11:0] TXDATA_OFFSET     = 12'h008;
   localparam logic [11:0] RXDATA_OFFSET     = 12'h00C;
   localparam int          CHECK_BIT         = 24;
   localparam int          RELEASE_BIT       = 22;
   localparam int          TARGET_DEVICE_SELECT_LSB        = 20;
   localparam int          LANE_LSB          = 18;
   localparam int          MODE_LSB          = 16;
   localparam int          COUNT_LSB         = 0;
   localparam int          TXFREE_LSB        = 16;
   localparam int          RXCNT_LSB         = 0;
   localparam logic [31:0] CTRL_WRITE_MASK   = 32'h017F_FFFF;
   localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
   localparam int          FIFO_DEPTH        = 4;
   localparam logic [7:0]  BUSY_STATUS_MASK  = 8'h01;
   localparam logic [2:0]  CS_GAP_CYCLES     = 3'h4;
   localparam logic [7:0]  STATUS_READ_CMD   = 8'h05;
   localparam logic [1:0]  MODE_IDLE         = 2'h0;
   localparam logic [1:0]  MODE_TX           = 2'h1;
   localparam logic [1:0]  MODE_RX           = 2'h2;
   localparam logic [1:0]  LANE_SINGLE       = 2'h0;
   localparam logic [1:0]  LANE_DUAL         = 2'h1;
   localparam logic [1:0]  LANE_QUAD         = 2'h2;
endpackage

// file: qsf_link.sv
// Purpose: Link-clock side shifter of the quad serial flash control block
// Assumes: Byte request arrives by toggle handshake from the register domain
// Notes:   Shifts one byte per request over 1, 2 or 4 lanes
`timescale 1ns/10ps
module qsf_link (
   // Link clock and reset
   input  wire logic       link_clk_i,
   input  wire logic       resetn_i,
   // Request from register domain
   input  wire logic       req_tgl_i,
   input  wire logic [7:0] tx_byte_i,
   input  wire logic [1:0] lane_i,
   input  wire logic       dir_rx_i,
   input  wire logic       cs_hold_i,
   input  wire logic       dev_i,
   // Answer to register domain
   output logic            ack_tgl_o,
   output logic [7:0]      rx_byte_o,
   // Flash pins
   output logic [1:0]      cs_n_o,
   output logic [3:0]      io_o,
   output logic [3:0]      io_oe_o,
   input  wire logic [3:0] io_i
);
   typedef enum logic [1:0] {L_IDLE, L_SHIFT, L_DONE} link_state_e;
   link_state_e state_reg, state_next;
   logic [2:0] req_sync_reg, req_sync_next;
   logic       ack_reg, ack_next;
   logic [7:0] sh_reg, sh_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [1:0] cs_n_reg, cs_n_next;
   logic [3:0] io_reg, io_next, oe_reg, oe_next;
   logic [7:0] rx_reg, rx_next;
   logic [3:0] steps;
   always_comb begin
      steps = (lane_i == qsf_pkg::LANE_QUAD) ? 4'd2 : (lane_i == qsf_pkg::LANE_DUAL) ? 4'd4 : 4'd8;
      req_sync_next = {req_sync_reg[1:0], req_tgl_i};
      state_next = state_reg;
      ack_next = ack_reg;
      sh_next = sh_reg;
      cnt_next = cnt_reg;
      cs_n_next = cs_n_reg;
      io_next = io_reg;
      oe_next = oe_reg;
      rx_next = rx_reg;
      case (state_reg)
         L_IDLE: begin
            if (cs_hold_i == 1'b0) begin
               cs_n_next = 2'b11;
            end
            if (req_sync_reg[2] != req_sync_reg[1]) begin
               state_next = L_SHIFT;
               sh_next = tx_byte_i;
               cnt_next = 4'd0;
               cs_n_next = dev_i ? 2'b01 : 2'b10;
            end
         end
         L_SHIFT: begin
            case (lane_i)
               qsf_pkg::LANE_QUAD: begin
                  io_next = sh_reg[7:4];
                  oe_next = dir_rx_i ? 4'h0 : 4'hF;
                  sh_next = {sh_reg[3:0], io_i};
               end
               qsf_pkg::LANE_DUAL: begin
                  io_next = {2'b00, sh_reg[7:6]};
                  oe_next = dir_rx_i ? 4'h0 : 4'h3;
                  sh_next = {sh_reg[5:0], io_i[1:0]};
               end
               default: begin
                  io_next = {3'b000, sh_reg[7]};
                  oe_next = dir_rx_i ? 4'h0 : 4'h1;
                  sh_next = {sh_reg[6:0], io_i[1]};
               end
            endcase
            cnt_next = cnt_reg + 4'd1;
            if (cnt_reg + 4'd1 == steps) begin
               state_next = L_DONE;
            end
         end
         L_DONE: begin
            oe_next = 4'h0;
            rx_next = sh_reg;
            ack_next = ~ack_reg;
            state_next = L_IDLE;
         end
         default: state_next = L_IDLE;
      endcase
   end
   always_ff @(posedge link_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= L_IDLE;
         req_sync_reg <= 3'b000;
         ack_reg <= 1'b0;
         sh_reg <= 8'h00;
         cnt_reg <= 4'h0;
         cs_n_reg <= 2'b11;
         io_reg <= 4'h0;
         oe_reg <= 4'h0;
         rx_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         req_sync_reg <= req_sync_next;
         ack_reg <= ack_next;
         sh_reg <= sh_next;
         cnt_reg <= cnt_next;
         cs_n_reg <= cs_n_next;
         io_reg <= io_next;
         oe_reg <= oe_next;
         rx_reg <= rx_next;
      end
   end
   assign ack_tgl_o = ack_reg;
   assign rx_byte_o = rx_reg;
   assign cs_n_o = cs_n_reg;
   assign io_o = io_reg;
   assign io_oe_o = oe_reg;
endmodule // qsf_link

// file: qsf_flash_model.sv
// Purpose: Behavioural serial flash pair at the far side of the link pins
// Assumes: Link logic moves its pins on the rising link clock edge
// Notes:   Every lane returns one level per frame; lines toggle while deselected
`timescale 1ns/10ps
module qsf_flash_model (
   // Link clock
   input  wire logic        link_clk_i,
   // Pins from the controller
   input  wire logic [1:0]  cs_n_i,
   input  wire logic [3:0]  io_i,
   input  wire logic [3:0]  io_oe_i,
   // Data back to the controller
   output logic [3:0]       io_o,
   // Bench control and observation
   input  wire logic [15:0] ones_until_i,
   output logic [15:0]      frames_o,
   output logic [7:0]       first_byte_o,
   output logic [1:0]       sel_seen_o,
   output logic [3:0]       oe_seen_o
);
   logic        sel_d;
   logic        idle_pat;
   logic [15:0] idx;
   int          nbits;

   initial begin
      sel_d = 1'b0;
      idle_pat = 1'b0;
      frames_o = 16'h0000;
      nbits = 0;
   end

   // Index of the frame in progress, or of the next one while deselected
   always_comb begin
      idx = (sel_d && cs_n_i != 2'b11) ? frames_o - 16'h0001 : frames_o;
   end

   // A released line never holds its last value
   assign io_o = (cs_n_i != 2'b11) ? {4{idx < ones_until_i}} : {4{idle_pat}};

   always @(posedge link_clk_i) begin
      idle_pat <= ~idle_pat;
   end

   always @(negedge link_clk_i) begin
      if (cs_n_i != 2'b11) begin
         if (!sel_d) begin
            frames_o = frames_o + 16'h0001;
            nbits = 0;
            first_byte_o = 8'h00;
            sel_seen_o = 2'b00;
            oe_seen_o = 4'h0;
         end
         sel_seen_o = sel_seen_o | ~cs_n_i;
         oe_seen_o = oe_seen_o | io_oe_i;
         if (io_oe_i[0] && nbits < 8) begin
            first_byte_o = {first_byte_o[6:0], io_i[0]};
            nbits++;
         end
      end
      sel_d = (cs_n_i != 2'b11);
   end
endmodule // qsf_flash_model

// file: quad_serial_flash_control_bench.sv
// Purpose: Self-checking bench of the quad serial flash control block
// Assumes: APB answers with one wait state; flash model on the link pins
// Notes:   Bit order of a byte on the wire is accepted either way round
`timescale 1ns/10ps
module quad_serial_flash_control_bench;
   logic        clk_i, resetn_i, link_clk_i, psel_i, penable_i, pwrite_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd, v;
   logic        pready_o, pslverr_o, err;
   logic [1:0]  cs_n_o, sel_seen;
   logic [3:0]  io_o, io_oe_o, io_i, oe_seen;
   logic [15:0] ones_until, frames, f;
   logic [7:0]  first_byte;
   logic [7:0]  txq[$];
   logic [3:0]  lane_oe[3] = '{4'h1, 4'h3, 4'hF};
   int          n_mismatch, cmp_count, seed, i, k;

   qsf_ctrl uut (.clk_i(clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .cs_n_o(cs_n_o), .io_o(io_o), .io_oe_o(io_oe_o), .io_i(io_i));
   qsf_flash_model flash (.link_clk_i(link_clk_i), .cs_n_i(cs_n_o), .io_i(io_o),
      .io_oe_i(io_oe_o), .io_o(io_i), .ones_until_i(ones_until), .frames_o(frames),
      .first_byte_o(first_byte), .sel_seen_o(sel_seen), .oe_seen_o(oe_seen));

   always #12.5 clk_i = ~clk_i;
   always #16 link_clk_i = ~link_clk_i;

   task automatic summarize;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer, held until pready is sampled high or 64 cycles pass
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 64);
      chk("apb answer", 32'h0000_0001, 32'(n < 64));
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, exp, rd);
   endtask

   task automatic push(input logic [7:0] b, input logic refuse);
      apb(1'b1, qsf_pkg::TXDATA_OFFSET, {24'h00_0000, b});
      chk("tx push error", 32'(refuse), 32'(err));
      if (!err) txq.push_back(b);
   endtask

   task automatic wait_field(input int lsb, input logic [7:0] val);
      for (int n = 0; n < 400; n++) begin
         apb(1'b0, qsf_pkg::STAT_OFFSET, 32'h0000_0000);
         if (rd[lsb+:8] === val) break;
      end
      for (k = 0; k < 2000 && cs_n_o !== 2'b11; k++) @(posedge clk_i);
      repeat (20) @(posedge clk_i);
   endtask

   function automatic logic [31:0] mk(input logic sc, rel, input logic [1:0] dev, lane,
         mode, input logic [15:0] cnt);
      return {7'h00, sc, 1'b0, rel, dev, lane, mode, cnt};
   endfunction

   function automatic logic [31:0] stat(input logic [7:0] free, rx);
      return {8'h00, free, 8'h00, rx};
   endfunction

   function automatic logic [31:0] norm(input logic [7:0] got, exp);
      logic [7:0] rev;
      rev = {<<{got}};
      return {24'h00_0000, (got == exp) ? got : rev};
   endfunction

   task automatic do_reset;
      resetn_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      txq.delete();
      rd_chk(qsf_pkg::CTRL_OFFSET, qsf_pkg::CTRL_RESET, "control after reset");
      rd_chk(qsf_pkg::STAT_OFFSET, stat(8'h04, 8'h00), "status after reset");
   endtask

   initial begin
      #1_000_000;
      chk("run finished", 32'h0000_0001, 32'h0000_0000);
      summarize();
   end

   initial begin
      clk_i = 1'b0;
      link_clk_i = 1'b0;
      resetn_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 12'h000;
      pwdata_i = 32'h0000_0000;
      ones_until = 16'h0000;
      seed = 32'h7962f409;
      n_mismatch = 0;
      cmp_count = 0;
      do_reset();
      for (i = 0; i < 4; i++) begin
         v = $random(seed);
         v[25] = 1'b0;
         v[21] = 1'b0;
         v[17:16] = qsf_pkg::MODE_IDLE;
         if (v[19:18] == 2'b11) v[18] = 1'b0;
         apb(1'b1, qsf_pkg::CTRL_OFFSET, v);
         rd_chk(qsf_pkg::CTRL_OFFSET, v & qsf_pkg::CTRL_WRITE_MASK, "control");
      end
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, 32'(err));
      chk("unmapped data", 32'h0000_0000, rd);
      apb(1'b1, qsf_pkg::CTRL_OFFSET, 32'h0000_0000);
      for (i = 0; i < 5; i++) push(8'($random(seed)), i == 4);
      rd_chk(qsf_pkg::STAT_OFFSET, stat(8'h00, 8'h00), "status full");
      repeat (50) @(posedge clk_i);
      chk("idle select", 32'h0000_0003, 32'(cs_n_o));
      chk("idle frames", 32'h0000_0000, 32'(frames));
      for (i = 0; i < 3; i++) begin
         f = frames;
         apb(1'b1, qsf_pkg::CTRL_OFFSET, mk(1'b0, 1'b1, 2'(i % 2), 2'(i),
            qsf_pkg::MODE_TX, (i == 0) ? 16'h0003 : 16'h0002));
         if (i > 0) push(8'($random(seed)), 1'b0);
         if (i > 0) push(8'($random(seed)), 1'b0);
         wait_field(16, 8'h03);
         rd_chk(qsf_pkg::STAT_OFFSET, stat(8'h03, 8'h00), "count left one");
         chk("frames", 32'(f + 16'h0001), 32'(frames));
         chk("device", (i % 2) ? 32'h0000_0002 : 32'h0000_0001, 32'(sel_seen));
         chk("lane enables", 32'(lane_oe[i]), 32'(oe_seen));
         if (i == 0) chk("first byte", 32'(txq[0]), norm(first_byte, txq[0]));
         repeat ((i == 0) ? 3 : 2) void'(txq.pop_front());
      end
      apb(1'b1, qsf_pkg::CTRL_OFFSET, mk(1'b0, 1'b0, 2'h0, qsf_pkg::LANE_SINGLE,
         qsf_pkg::MODE_TX, 16'h0001));
      wait_field(16, 8'h04);
      chk("select held", 32'h0000_0002, 32'(cs_n_o));
      do_reset();
      f = frames;
      ones_until = f + 16'h0002;
      apb(1'b1, qsf_pkg::CTRL_OFFSET, mk(1'b1, 1'b1, 2'h0, qsf_pkg::LANE_SINGLE,
         qsf_pkg::MODE_TX, 16'h0001));
      push(8'($random(seed)), 1'b0);
      for (k = 0; k < 4000 && !(frames === f + 16'h0003 && cs_n_o === 2'b11); k++)
         @(posedge clk_i);
      repeat (100) @(posedge clk_i);
      chk("status polls", 32'(f + 16'h0003), 32'(frames));
      chk("poll command", 32'(qsf_pkg::STATUS_READ_CMD),
         norm(first_byte, qsf_pkg::STATUS_READ_CMD));
      ones_until = 16'hFFFF;
      apb(1'b1, qsf_pkg::CTRL_OFFSET, mk(1'b0, 1'b1, 2'h1, qsf_pkg::LANE_QUAD,
         qsf_pkg::MODE_RX, 16'h0003));
      wait_field(0, 8'h03);
      rd_chk(qsf_pkg::STAT_OFFSET, stat(8'h04, 8'h03), "rx held");
      repeat (3) rd_chk(qsf_pkg::RXDATA_OFFSET, 32'h0000_00FF, "rx data");
      rd_chk(qsf_pkg::STAT_OFFSET, stat(8'h04, 8'h00), "rx drained");
      summarize();
   end
endmodule // quad_serial_flash_control_bench
